// ---- hgsb_defines.svh ----
`ifndef HGSB_DEFINES_SVH
`define HGSB_DEFINES_SVH

// Register offsets
`define HGSB_ADDR_REV 8'h03
`define HGSB_ADDR_STATUS 8'h04
`define HGSB_ADDR_PAR_HI 8'h05
`define HGSB_ADDR_PAR_LO 8'h06
`define HGSB_ADDR_WDOG 8'h07
`define HGSB_ADDR_I2C1 8'h08

// Reset values
`define HGSB_RST_STATUS 8'hC0
`define HGSB_RST_PAR_HI 8'h01
`define HGSB_RST_PAR_LO 8'h00
`define HGSB_RST_WDOG 8'hFE
`define HGSB_RST_I2C1 8'h1C

// Field positions
`define HGSB_ST_CKSUM_BIT 7
`define HGSB_ST_DONE_BIT 6
`define HGSB_ST_REFOK_BIT 4
`define HGSB_WD_CNT_HI 7
`define HGSB_WD_CNT_LO 1
`define HGSB_WD_OFF_BIT 0
`define HGSB_I2C_LOCK_BIT 7
`define HGSB_I2C_HOLD_HI 6
`define HGSB_I2C_HOLD_LO 4
`define HGSB_I2C_FILT_HI 3
`define HGSB_I2C_FILT_LO 0

// Timing
`define HGSB_CLK_PERIOD_NS 10
`define HGSB_WDOG_STEP_NS 2000000
`define HGSB_HOLD_UNIT_NS 50
`define HGSB_FILT_UNIT_NS 5
`define HGSB_REF_WINDOW_NS 1000
`define HGSB_REF_MIN_MHZ 12
`define HGSB_REF_MAX_MHZ 64

`endif

// ---- hgsb_pkg.sv ----
package hgsb_pkg;

	typedef struct packed {
		logic valid;
		logic write;
		logic remote;
		logic target;
		logic [7:0] addr;
		logic [7:0] data;
	} hgsb_req_t;

	typedef struct packed {
		logic valid;
		logic rejected;
		logic [7:0] data;
	} hgsb_resp_t;

	typedef enum logic [0:0] {
		HGSB_ST_READY = 1'b0,
		HGSB_ST_LOAD = 1'b1
	} hgsb_init_state_t;

endpackage

// ---- hgsb_port_parity.sv ----
`timescale 1ns/1ps
module hgsb_port_parity #(
	parameter int WIDTH = 16
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic err_i,
	input wire logic check_en_i,
	input wire logic clr_i,
	input wire logic [WIDTH-1:0] limit_i,
	output logic flag_o,
	output logic [WIDTH-1:0] count_o
);
	import hgsb_pkg::*;

	logic hit;

	// Saturate so a long error burst cannot wrap below the limit
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_o <= '0;
		end else if (clr_i) begin
			count_o <= '0;
		end else if (err_i && check_en_i && (count_o != '1)) begin
			count_o <= count_o + 1'b1;
		end
	end

	assign hit = (count_o >= limit_i);

	// Set wins over the clear
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag_o <= 1'b0;
		end else if (hit) begin
			flag_o <= 1'b1;
		end else if (clr_i) begin
			flag_o <= 1'b0;
		end
	end

	property p_flag_on_limit;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(count_o >= limit_i) |=> flag_o;
	endproperty
	a_flag_on_limit: assert property (p_flag_on_limit)
		else $error("parity flag missed limit");

	property p_count_gated;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!check_en_i && !clr_i) |=> $stable(count_o);
	endproperty
	a_count_gated: assert property (p_count_gated)
		else $error("parity count moved while disabled");

endmodule // hgsb_port_parity

// ---- hgsb_top.sv ----
// How it works
// - Revision register: revision code high nibble, mask code low.
// - Status bit 7 shows fuse checksum valid after load.
// - Status bit 6 set when initialization and fuse load finish.
// - Status bit 4 high for 12 to 64 reference edges seen per microsecond; references above half the clock alias.
// - Parity limit is high byte over low byte, sixteen bits.
// - Port flag sets when its error count reaches the limit.
// - Control-channel transaction aborted when watchdog times out.
// - Timeout equals bits 7:1 times two milliseconds.
// - Watchdog bit 0 high stops the watchdog; low runs it.
// - Lockout bit 7 rejects remote writes to these registers.
// - Lockout never blocks remote accesses forwarded to hub targets.
// - SDA input held by bits 6:4 times fifty nanoseconds.
// - Glitches up to bits 3:0 times five nanoseconds rejected.
// - Parity errors counted only while the check enable is set.
// - Fuse reload clears init-done until the reload completes.
`timescale 1ns/1ps
`include "hgsb_defines.svh"
module hgsb_top #(
	parameter int PORTS = 4,
	parameter int PAR_WIDTH = 16,
	parameter int WDOG_STEP_CYCLES = `HGSB_WDOG_STEP_NS / `HGSB_CLK_PERIOD_NS,
	parameter logic [3:0] SILICON_REV = 4'h9, // arbitrary value
	parameter logic [3:0] MASK_LEVEL = 4'h0 // arbitrary value
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire hgsb_pkg::hgsb_req_t req_i,
	output hgsb_pkg::hgsb_resp_t resp_o,
	output hgsb_pkg::hgsb_req_t fwd_o,
	input wire logic fuse_reload_request_i,
	input wire logic fuse_done_i,
	input wire logic fuse_checksum_ok_i,
	output logic fuse_load_o,
	input wire logic external_ref_clock_i,
	input wire logic parity_check_en_i,
	input wire logic [PORTS-1:0] par_err_i,
	input wire logic [PORTS-1:0] par_flag_clr_i,
	output logic [PORTS-1:0] par_flag_o,
	input wire logic cc_busy_i,
	output logic cc_abort_o,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_filt_o,
	output logic sda_filt_o
);
	import hgsb_pkg::*;

	localparam int HOLD_UNIT_CYC = (`HGSB_HOLD_UNIT_NS +
		`HGSB_CLK_PERIOD_NS - 1) / `HGSB_CLK_PERIOD_NS;
	localparam int HOLD_TAPS = 7 * HOLD_UNIT_CYC;
	localparam int REF_WIN_CYC = `HGSB_REF_WINDOW_NS / `HGSB_CLK_PERIOD_NS;
	localparam int REF_MIN_EDGES = `HGSB_REF_MIN_MHZ * `HGSB_REF_WINDOW_NS
		/ 1000;
	localparam int REF_MAX_EDGES = `HGSB_REF_MAX_MHZ * `HGSB_REF_WINDOW_NS
		/ 1000;

	logic rst_meta;
	logic rst_n;
	logic [7:0] par_hi;
	logic [7:0] par_lo;
	logic [7:0] wdog;
	logic [7:0] i2c1;
	logic fuse_checksum_ok;
	logic init_done;
	logic ext_clock_freq_ok;
	hgsb_init_state_t state;
	logic [PAR_WIDTH-1:0] parity_limit;
	logic lock;
	logic wr_ok;
	logic wr_reject;
	logic [7:0] next_rdata;
	logic [31:0] wd_cnt;
	logic [31:0] wd_limit;
	logic wd_fired;
	logic ref_prev;
	logic [7:0] ref_edges;
	logic [7:0] ref_win;
	logic [3:0] filt_lim;
	logic [1:0] line_in;
	logic [1:0] filt_q;
	logic [HOLD_TAPS-1:0] sda_dly;
	logic [5:0] hold_idx;

	// Reset release through two flops
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	assign parity_limit = {par_hi, par_lo};
	assign lock = i2c1[`HGSB_I2C_LOCK_BIT];
	assign wr_ok = req_i.valid && req_i.write && !req_i.target &&
		!(req_i.remote && lock);
	assign wr_reject = req_i.valid && req_i.write && !req_i.target &&
		req_i.remote && lock;

	// Writable configuration
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			par_hi <= `HGSB_RST_PAR_HI;
			par_lo <= `HGSB_RST_PAR_LO;
			wdog <= `HGSB_RST_WDOG;
			i2c1 <= `HGSB_RST_I2C1;
		end else if (wr_ok) begin
			if (req_i.addr == `HGSB_ADDR_PAR_HI) begin
				par_hi <= req_i.data;
			end else if (req_i.addr == `HGSB_ADDR_PAR_LO) begin
				par_lo <= req_i.data;
			end else if (req_i.addr == `HGSB_ADDR_WDOG) begin
				wdog <= req_i.data;
			end else if (req_i.addr == `HGSB_ADDR_I2C1) begin
				i2c1 <= req_i.data;
			end
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = 8'h00;
		if (req_i.addr == `HGSB_ADDR_REV) begin
			next_rdata = {SILICON_REV, MASK_LEVEL};
		end else if (req_i.addr == `HGSB_ADDR_STATUS) begin
			next_rdata[`HGSB_ST_CKSUM_BIT] = fuse_checksum_ok;
			next_rdata[`HGSB_ST_DONE_BIT] = init_done;
			next_rdata[`HGSB_ST_REFOK_BIT] = ext_clock_freq_ok;
		end else if (req_i.addr == `HGSB_ADDR_PAR_HI) begin
			next_rdata = par_hi;
		end else if (req_i.addr == `HGSB_ADDR_PAR_LO) begin
			next_rdata = par_lo;
		end else if (req_i.addr == `HGSB_ADDR_WDOG) begin
			next_rdata = wdog;
		end else if (req_i.addr == `HGSB_ADDR_I2C1) begin
			next_rdata = i2c1;
		end
	end

	// Answer one cycle after each local register request
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			resp_o <= '0;
		end else begin
			resp_o.valid <= req_i.valid && !req_i.target;
			resp_o.rejected <= wr_reject;
			resp_o.data <= (req_i.valid && !req_i.write && !req_i.target) ?
				next_rdata : 8'h00;
		end
	end

	// Target accesses pass regardless of lockout
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fwd_o <= '0;
		end else if (req_i.valid && req_i.target) begin
			fwd_o <= req_i;
		end else begin
			fwd_o.valid <= 1'b0;
		end
	end

	// Fuse load sequencing; status shows loaded at release
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= HGSB_ST_READY;
			fuse_load_o <= 1'b0;
			init_done <= 1'(`HGSB_RST_STATUS >> `HGSB_ST_DONE_BIT);
			fuse_checksum_ok <= 1'(`HGSB_RST_STATUS >> `HGSB_ST_CKSUM_BIT);
		end else begin
			case (state)
				HGSB_ST_READY: begin
					if (fuse_reload_request_i) begin
						state <= HGSB_ST_LOAD;
						fuse_load_o <= 1'b1;
						init_done <= 1'b0;
					end
				end
				HGSB_ST_LOAD: begin
					if (fuse_done_i) begin
						state <= HGSB_ST_READY;
						fuse_load_o <= 1'b0;
						init_done <= 1'b1;
						fuse_checksum_ok <= fuse_checksum_ok_i;
					end
				end
				default: begin
					state <= HGSB_ST_READY;
					fuse_load_o <= 1'b0;
				end
			endcase
		end
	end

	// Edge count over a fixed window; aliases above half the clock
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ref_prev <= 1'b0;
			ref_edges <= 8'h00;
			ref_win <= 8'h00;
			ext_clock_freq_ok <= 1'b0;
		end else begin
			ref_prev <= external_ref_clock_i;
			if (ref_win == 8'(REF_WIN_CYC - 1)) begin
				ref_win <= 8'h00;
				ref_edges <= 8'h00;
				ext_clock_freq_ok <= (ref_edges >= 8'(REF_MIN_EDGES)) &&
					(ref_edges <= 8'(REF_MAX_EDGES));
			end else begin
				ref_win <= ref_win + 8'h01;
				if (external_ref_clock_i && !ref_prev) begin
					ref_edges <= ref_edges + 8'h01;
				end
			end
		end
	end

	assign wd_limit = 32'(wdog[`HGSB_WD_CNT_HI:`HGSB_WD_CNT_LO]) *
		32'(WDOG_STEP_CYCLES);

	// Fires once per transaction; zero timeout fires only after the 32-bit count wraps
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wd_cnt <= 32'h0000_0000;
			wd_fired <= 1'b0;
			cc_abort_o <= 1'b0;
		end else begin
			cc_abort_o <= 1'b0;
			if (!cc_busy_i || wdog[`HGSB_WD_OFF_BIT]) begin
				wd_cnt <= 32'h0000_0000;
				wd_fired <= 1'b0;
			end else if (!wd_fired) begin
				wd_cnt <= wd_cnt + 32'h0000_0001;
				if (wd_cnt + 32'h0000_0001 == wd_limit) begin
					cc_abort_o <= 1'b1;
					wd_fired <= 1'b1;
				end
			end
		end
	end

	assign filt_lim = 4'((32'(i2c1[`HGSB_I2C_FILT_HI:`HGSB_I2C_FILT_LO]) *
		`HGSB_FILT_UNIT_NS + `HGSB_CLK_PERIOD_NS - 1) /
		`HGSB_CLK_PERIOD_NS);
	assign line_in = {sda_i, scl_i};

	// Glitch filter on each I2C input line
	genvar li;
	generate
		for (li = 0; li < 2; li++) begin : g_filt
			logic [3:0] cnt;
			always_ff @(posedge sys_clk_i or negedge rst_n) begin
				if (!rst_n) begin
					cnt <= 4'h0;
					filt_q[li] <= 1'b1;
				end else if (line_in[li] == filt_q[li]) begin
					cnt <= 4'h0;
				end else if (cnt >= filt_lim) begin
					cnt <= 4'h0;
					filt_q[li] <= line_in[li];
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	endgenerate

	assign hold_idx = 6'(32'(i2c1[`HGSB_I2C_HOLD_HI:`HGSB_I2C_HOLD_LO]) *
		HOLD_UNIT_CYC);

	// Delayed SDA gives hold time against SCL
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sda_dly <= '1;
			scl_filt_o <= 1'b1;
			sda_filt_o <= 1'b1;
		end else begin
			sda_dly <= {sda_dly[HOLD_TAPS-2:0], filt_q[1]};
			scl_filt_o <= filt_q[0];
			sda_filt_o <= (hold_idx == 6'h00) ? filt_q[1] :
				sda_dly[hold_idx - 6'h01];
		end
	end

	genvar pi;
	generate
		for (pi = 0; pi < PORTS; pi++) begin : g_port
			hgsb_port_parity #(
				.WIDTH(PAR_WIDTH)
			) u_par (
				.sys_clk_i(sys_clk_i),
				.rst_n_i(rst_n),
				.err_i(par_err_i[pi]),
				.check_en_i(parity_check_en_i),
				.clr_i(par_flag_clr_i[pi]),
				.limit_i(parity_limit),
				.flag_o(par_flag_o[pi]),
				.count_o()
			);
		end
	endgenerate

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n);

	property p_rev_read;
		req_i.valid && !req_i.write && !req_i.target &&
		req_i.addr == `HGSB_ADDR_REV |=>
		resp_o.valid && resp_o.data == {SILICON_REV, MASK_LEVEL};
	endproperty
	a_rev_read: assert property (p_rev_read)
		else $error("revision read wrong");

	property p_cksum_load;
		state == HGSB_ST_LOAD && fuse_done_i |=>
		fuse_checksum_ok == $past(fuse_checksum_ok_i) && init_done;
	endproperty
	a_cksum_load: assert property (p_cksum_load)
		else $error("checksum bit not loaded");

	property p_reload_clears;
		state == HGSB_ST_READY && fuse_reload_request_i |=>
		!init_done && fuse_load_o;
	endproperty
	a_reload_clears: assert property (p_reload_clears)
		else $error("reload did not clear done");

	property p_ref_stable;
		ref_win != 8'(REF_WIN_CYC - 1) |=> $stable(ext_clock_freq_ok);
	endproperty
	a_ref_stable: assert property (p_ref_stable)
		else $error("reference flag moved mid window");

	property p_hi_write;
		wr_ok && req_i.addr == `HGSB_ADDR_PAR_HI |=>
		parity_limit[15:8] == $past(req_i.data);
	endproperty
	a_hi_write: assert property (p_hi_write)
		else $error("high byte not stored");

	property p_lockout;
		wr_reject |=> resp_o.rejected && $stable(par_hi) &&
		$stable(par_lo) && $stable(wdog) && $stable(i2c1);
	endproperty
	a_lockout: assert property (p_lockout)
		else $error("remote write not rejected");

	property p_fwd;
		req_i.valid && req_i.target |=> fwd_o.valid && !resp_o.valid;
	endproperty
	a_fwd: assert property (p_fwd)
		else $error("target access not forwarded");

	property p_wd_off;
		wdog[`HGSB_WD_OFF_BIT] |=> !cc_abort_o;
	endproperty
	a_wd_off: assert property (p_wd_off)
		else $error("abort while watchdog off");

	property p_wd_time;
		cc_abort_o |-> $past(wd_cnt) + 32'h0000_0001 == wd_limit;
	endproperty
	a_wd_time: assert property (p_wd_time)
		else $error("abort at wrong time");

	c_abort: cover property (cc_abort_o);
	c_reject: cover property (resp_o.rejected);
	c_reload: cover property (state == HGSB_ST_LOAD ##1 init_done);
	c_flag: cover property (|par_flag_o);

endmodule // hgsb_top

// ---- hgsb_fuse_model.sv ----
`timescale 1ns/1ps
module hgsb_fuse_model #(
	parameter int DELAY = 10
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic fuse_load_i,
	input wire logic ok_sel_i,
	output logic fuse_done_o,
	output logic fuse_checksum_ok_o
);
	int cnt;
	// Checksum toggles outside done so a stale value never passes
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt <= 0;
			fuse_done_o <= 1'b0;
			fuse_checksum_ok_o <= 1'b0;
		end else begin
			fuse_done_o <= 1'b0;
			fuse_checksum_ok_o <= ~fuse_checksum_ok_o;
			if (!fuse_load_i) begin
				cnt <= 0;
			end else if (cnt == DELAY) begin
				cnt <= cnt + 1;
				fuse_done_o <= 1'b1;
				fuse_checksum_ok_o <= ok_sel_i;
			end else if (cnt < DELAY) begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule // hgsb_fuse_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import hgsb_pkg::*;
	localparam int STEP = 4;
	localparam logic [7:0] ADDR [6] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
	localparam logic [7:0] RSTV [6] = '{8'h90, 8'hC0, 8'h01, 8'h00, 8'hFE, 8'h1C};
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	hgsb_req_t req = '0;
	hgsb_resp_t resp;
	hgsb_req_t fwd;
	logic reload = 1'b0, fuse_done, fuse_ok, fuse_load, ok_sel = 1'b0;
	logic ext_ref = 1'b0, ref_run = 1'b0, par_en = 1'b0, busy = 1'b0;
	logic [3:0] par_err = '0, par_clr = '0, par_flag;
	logic abort, scl = 1'b1, sda = 1'b1, scl_f, sda_f;
	int error_cnt = 0, check_count = 0, cycles = 0, n, ns;
	always #5 sys_clk = ~sys_clk;
	// Stands still unless a scenario runs it
	// Period kept off the sampling edge so no race
	always #24 ext_ref = ref_run ? ~ext_ref : 1'b0;
	hgsb_top #(.WDOG_STEP_CYCLES(STEP)) hgsb_top_inst (
		.sys_clk_i(sys_clk), .resetn_i(resetn), .req_i(req), .resp_o(resp),
		.fwd_o(fwd), .fuse_reload_request_i(reload), .fuse_done_i(fuse_done),
		.fuse_checksum_ok_i(fuse_ok), .fuse_load_o(fuse_load),
		.external_ref_clock_i(ext_ref), .parity_check_en_i(par_en),
		.par_err_i(par_err), .par_flag_clr_i(par_clr), .par_flag_o(par_flag),
		.cc_busy_i(busy), .cc_abort_o(abort), .scl_i(scl), .sda_i(sda),
		.scl_filt_o(scl_f), .sda_filt_o(sda_f)
	);
	hgsb_fuse_model hgsb_fuse_model_inst (
		.sys_clk_i(sys_clk), .resetn_i(resetn), .fuse_load_i(fuse_load),
		.ok_sel_i(ok_sel), .fuse_done_o(fuse_done),
		.fuse_checksum_ok_o(fuse_ok)
	);
	task give_verdict();
		$display("Checks %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			$display("CHECK FAILED run length expected <20000 seen 20000");
			give_verdict();
		end
	end
	task chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chk_bit(input string nm, input logic e, input logic g);
		chk_byte(nm, {7'h00, e}, {7'h00, g});
	endtask
	task tick(input int k);
		repeat (k) begin
			@(posedge sys_clk);
			#1;
		end
	endtask
	// Leaves the bench in the answer cycle
	task send(input logic w, input logic rem, input logic tgt,
		input logic [7:0] a, input logic [7:0] d);
		tick(1);
		req = '{1'b1, w, rem, tgt, a, d};
		tick(1);
		req = '0;
	endtask
	task rd(input logic rem, input logic [7:0] a, input logic [7:0] e);
		send(1'b0, rem, 1'b0, a, 8'h00);
		chk_bit("read valid", 1'b1, resp.valid);
		chk_byte("read data", e, resp.data);
	endtask
	task wr(input logic rem, input logic [7:0] a, input logic [7:0] d,
		input logic rej);
		send(1'b1, rem, 1'b0, a, d);
		chk_bit("write valid", 1'b1, resp.valid);
		chk_bit("write rejected", rej, resp.rejected);
	endtask
	task glitch(output int bad);
		bad = 0;
		scl = 1'b0;
		repeat (3) begin
			tick(1);
			if (scl_f !== 1'b1) bad++;
		end
		scl = 1'b1;
		repeat (10) begin
			tick(1);
			if (scl_f !== 1'b1) bad++;
		end
	endtask
	initial begin
		tick(2);
		resetn = 1'b1;
		tick(4);
		for (int i = 0; i < 6; i++) begin
			rd(1'b0, ADDR[i], RSTV[i]);
		end
		wr(1'b0, 8'h03, 8'hFF, 1'b0);
		rd(1'b0, 8'h03, 8'h90);
		wr(1'b0, 8'h04, 8'h00, 1'b0);
		rd(1'b0, 8'h04, 8'hC0);
		rd(1'b0, 8'h20, 8'h00);
		wr(1'b0, 8'h05, 8'hA5, 1'b0);
		wr(1'b0, 8'h06, 8'h5A, 1'b0);
		rd(1'b0, 8'h05, 8'hA5);
		rd(1'b0, 8'h06, 8'h5A);
		wr(1'b0, 8'h08, 8'h9C, 1'b0);
		wr(1'b1, 8'h05, 8'h00, 1'b1);
		rd(1'b1, 8'h05, 8'hA5);
		send(1'b1, 1'b1, 1'b1, 8'h42, 8'h33);
		chk_bit("forward valid", 1'b1, fwd.valid);
		chk_byte("forward addr", 8'h42, fwd.addr);
		chk_byte("forward data", 8'h33, fwd.data);
		chk_bit("forward answered", 1'b0, resp.valid);
		wr(1'b0, 8'h08, 8'h1C, 1'b0);
		wr(1'b1, 8'h05, 8'h00, 1'b0);
		wr(1'b0, 8'h06, 8'h03, 1'b0);
		rd(1'b0, 8'h05, 8'h00);
		par_en = 1'b1;
		par_err = 4'h1;
		tick(2);
		par_err = 4'h0;
		tick(3);
		chk_byte("flags below limit", 8'h00, {4'h0, par_flag});
		par_err = 4'h1;
		tick(1);
		par_err = 4'h0;
		tick(3);
		chk_byte("flags at limit", 8'h01, {4'h0, par_flag});
		par_en = 1'b0;
		par_err = 4'h2;
		tick(5);
		par_err = 4'h0;
		tick(3);
		chk_byte("flags check off", 8'h01, {4'h0, par_flag});
		// Count still at the limit on the first clear edge, so set wins
		par_clr = 4'h1;
		tick(1);
		chk_byte("flag set wins", 8'h01, {4'h0, par_flag});
		tick(1);
		par_clr = 4'h0;
		tick(1);
		chk_byte("flags cleared", 8'h00, {4'h0, par_flag});
		wr(1'b0, 8'h07, 8'h04, 1'b0);
		busy = 1'b1;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (abort !== 1'b1 && n < 50);
		chk_byte("abort cycle", 8'h08, 8'(n));
		tick(1);
		chk_bit("abort pulse", 1'b0, abort);
		busy = 1'b0;
		wr(1'b0, 8'h07, 8'h05, 1'b0);
		busy = 1'b1;
		ns = 0;
		repeat (20) begin
			tick(1);
			if (abort !== 1'b0) ns++;
		end
		busy = 1'b0;
		chk_byte("abort when off", 8'h00, 8'(ns));
		ref_run = 1'b1;
		tick(300);
		rd(1'b0, 8'h04, 8'hD0);
		ref_run = 1'b0;
		tick(300);
		rd(1'b0, 8'h04, 8'hC0);
		for (int i = 0; i < 2; i++) begin
			ok_sel = 1'(i);
			reload = 1'b1;
			tick(1);
			reload = 1'b0;
			chk_bit("loading", 1'b1, fuse_load);
			send(1'b0, 1'b0, 1'b0, 8'h04, 8'h00);
			chk_bit("init done", 1'b0, resp.data[6]);
			tick(15);
			rd(1'b0, 8'h04, i ? 8'hC0 : 8'h40);
		end
		glitch(ns);
		chk_byte("long filter glitch", 8'h00, 8'(ns));
		scl = 1'b0;
		sda = 1'b0;
		n = 0;
		ns = 0;
		repeat (40) begin
			tick(1);
			if (scl_f !== 1'b0) n++;
			if (sda_f !== 1'b0) ns++;
		end
		chk_byte("sda hold lag", 8'h05, 8'(ns - n));
		scl = 1'b1;
		sda = 1'b1;
		wr(1'b0, 8'h08, 8'h10, 1'b0);
		tick(40);
		glitch(ns);
		chk_bit("short filter glitch", 1'b1, ns > 0);
		give_verdict();
	end
endmodule // tb_top
